//--- shared/aocc_cfg.svh
// register offsets, field positions, reset values and timing counts of the output and core config block
`ifndef AOCC_CFG_SVH
`define AOCC_CFG_SVH

// register offsets
`define AOCC_ADDR_RESULT 4'h0
`define AOCC_ADDR_CFG0 4'h1
`define AOCC_ADDR_CFG1 4'h2

// reset values
`define AOCC_CFG0_RESET 8'hc0
`define AOCC_CFG1_RESET 8'h0c

// core_config_zero field positions
`define AOCC_CFG0_PSHDN_BIT 7
`define AOCC_CFG0_VREF_BIT 6
`define AOCC_CFG0_CLK_MSB 5
`define AOCC_CFG0_CLK_LSB 4
`define AOCC_CFG0_BIAS_MSB 3
`define AOCC_CFG0_BIAS_LSB 2
`define AOCC_CFG0_MODE_MSB 1
`define AOCC_CFG0_MODE_LSB 0

// clock_oversample_config field positions
`define AOCC_CFG1_PRE_MSB 7
`define AOCC_CFG1_PRE_LSB 6
`define AOCC_CFG1_OSR_MSB 5
`define AOCC_CFG1_OSR_LSB 2

// field codes
`define AOCC_MODE_CONV 2'h3
`define AOCC_MODE_STBY 2'h2
`define AOCC_CLK_INT_OUT 2'h3
`define AOCC_CONV_CONTINUOUS 2'h3

// timing counts: prescaler and ratio counter widths and gain fraction bits
`define AOCC_PRE_CNT_W 3
`define AOCC_OSR_CNT_W 17
`define AOCC_GAIN_FRAC 23

`endif

//--- shared/aocc_pkg.sv
// types shared by the output and core config block
package aocc_pkg;
  typedef logic [7:0] aocc_byte_t;
  typedef logic [23:0] aocc_word24_t;
  typedef logic [31:0] aocc_word32_t;
  typedef enum logic [1:0] {AOCC_IDLE, AOCC_RUN} aocc_conv_state_t;
endpackage

//--- design/aocc_result_buf.sv
// double buffer for the conversion result: newest value and read snapshot
`timescale 1ns/10ps
module aocc_result_buf #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // writer side
  input wire logic load,
  input wire logic [DW-1:0] load_data,
  input wire logic load_modulator_raw_output,
  // reader side
  input wire logic capture,
  output logic [DW-1:0] snap_data,
  output logic snap_modulator_raw_output
);
  logic [DW-1:0] latest_q, latest_d;
  logic latest_modulator_raw_output_q, latest_modulator_raw_output_d;
  logic [DW-1:0] snap_q, snap_d;
  logic snap_modulator_raw_output_q, snap_modulator_raw_output_d;

  // ************************************************
  // next values
  // ************************************************
  // a load never disturbs the snapshot, so a read in flight keeps its word
  always_comb begin
    latest_d = latest_q;
    latest_modulator_raw_output_d = latest_modulator_raw_output_q;
    snap_d = snap_q;
    snap_modulator_raw_output_d = snap_modulator_raw_output_q;
    if (load) begin
      latest_d = load_data;
      latest_modulator_raw_output_d = load_modulator_raw_output;
    end
    if (capture) begin
      snap_d = latest_q; // older word when load collides
      snap_modulator_raw_output_d = latest_modulator_raw_output_q;
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latest_q <= '0;
      latest_modulator_raw_output_q <= 1'b0;
      snap_q <= '0;
      snap_modulator_raw_output_q <= 1'b0;
    end else if (clk_en) begin
      latest_q <= latest_d;
      latest_modulator_raw_output_q <= latest_modulator_raw_output_d;
      snap_q <= snap_d;
      snap_modulator_raw_output_q <= snap_modulator_raw_output_d;
    end
  end

  assign snap_data = snap_q;
  assign snap_modulator_raw_output = snap_modulator_raw_output_q;
endmodule

//--- design/aocc_core.sv
// conversion result path, core_config_zero and clock_oversample_config of the converter control
// How it works
// - with offset or gain calibration on, the stored result is the calibrated value.
// - the result reads as 24 bits or 32 bits according to the output data format field.
// - the stored result is refreshed at every internal data-ready event, paced by prescaler, ratio and mode.
// - the stored result is captured when a read command starts and stays fixed for that transfer.
// - the result is double buffered so a conversion landing during a read is kept.
// - with the upper irq mode bit set, the result shrinks to the four raw modulator outputs.
// - reference select bit 6 picks the buffered internal 2.4V reference when set, external when clear.
// - the burnout field picks 15, 3.7, 0.9 or no microamps, sourced on the plus and sunk on the minus input.
// - prescaler bits 7-6 divide the master clock by 1, 2, 4 or the largest ratio of 8.
// - ratio bits 5-2 select 32 up to 98304, reset code 0011 giving 256.
`timescale 1ns/10ps
`include "aocc_cfg.svh"
module aocc_core (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // register port from the serial command decoder
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr_en,
  input wire aocc_pkg::aocc_byte_t reg_wdata,
  input wire logic reg_rd_start,
  output aocc_pkg::aocc_word32_t rd_data,
  output logic rd_valid,
  // converter datapath and settings held elsewhere
  input wire aocc_pkg::aocc_word24_t filter_result,
  input wire logic [3:0] modulator_raw_output,
  input wire logic offset_cal_enable,
  input wire logic gain_cal_enable,
  input wire aocc_pkg::aocc_word24_t offset_cal_value,
  input wire aocc_pkg::aocc_word24_t gain_cal_value,
  input wire logic [1:0] data_format,
  input wire logic [1:0] conversion_mode_select,
  input wire logic irq_mode_upper,
  // master clock sources as one-cycle ticks
  input wire logic ext_clk_tick,
  input wire logic int_osc_tick,
  // analog controls
  output logic vref_internal,
  output logic partial_shutdown_n,
  output logic [1:0] bias_current_sel,
  output logic [1:0] adc_mode,
  output logic [3:0] oversampling_ratio,
  // clock pin and event
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic data_ready
);
  import aocc_pkg::*;

  // ************************************************
  // functions
  // ************************************************
  // last count of the prescaler for a division code
  function automatic logic [`AOCC_PRE_CNT_W-1:0] pre_last(input logic [1:0] code);
    case (code)
      2'h0: pre_last = 3'h0;
      2'h1: pre_last = 3'h1;
      2'h2: pre_last = 3'h3;
      default: pre_last = 3'h7;
    endcase
  endfunction

  // oversampling ratio for a ratio code
  function automatic logic [`AOCC_OSR_CNT_W-1:0] osr_value(input logic [3:0] code);
    case (code)
      4'h0: osr_value = 17'h00020;
      4'h1: osr_value = 17'h00040;
      4'h2: osr_value = 17'h00080;
      4'h3: osr_value = 17'h00100;
      4'h4: osr_value = 17'h00200;
      4'h5: osr_value = 17'h00400;
      4'h6: osr_value = 17'h00800;
      4'h7: osr_value = 17'h01000;
      4'h8: osr_value = 17'h02000;
      4'h9: osr_value = 17'h04000;
      4'ha: osr_value = 17'h05000;
      4'hb: osr_value = 17'h06000;
      4'hc: osr_value = 17'h0a000;
      4'hd: osr_value = 17'h0c000;
      4'he: osr_value = 17'h14000;
      default: osr_value = 17'h18000;
    endcase
  endfunction

  // clamp a wide signed value into 24 bits
  function automatic aocc_word24_t sat24(input logic signed [49:0] v);
    if (v > 50'sh00000007fffff) begin
      sat24 = 24'h7fffff;
    end else if (v < -50'sh000000800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // ************************************************
  // state
  // ************************************************
  aocc_byte_t cfg0_q, cfg0_d;
  aocc_byte_t cfg1_q, cfg1_d;
  logic [`AOCC_PRE_CNT_W-1:0] pre_cnt_q, pre_cnt_d;
  logic [`AOCC_OSR_CNT_W-1:0] osr_cnt_q, osr_cnt_d;
  aocc_conv_state_t st_q, st_d;
  logic analog_master_clock_q, analog_master_clock_d;
  logic clk_oe_q, clk_oe_d;
  logic ready_q, ready_d;
  logic rd_pend_q, rd_pend_d;
  logic [3:0] rd_addr_q, rd_addr_d;
  aocc_word32_t rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;

  logic mclk_tick;
  logic analog_master_clock_tick;
  logic conv_done;
  logic oneshot_stop;
  logic cfg_written;
  logic buf_load;
  aocc_word24_t buf_load_data;
  aocc_word24_t snap_data;
  logic snap_modulator_raw_output;
  aocc_word24_t cal_value;
  logic signed [24:0] off_sum;
  logic signed [49:0] gain_prod;

  // ************************************************
  // clock selection and prescaler
  // ************************************************
  assign mclk_tick = cfg0_q[`AOCC_CFG0_CLK_MSB] ? int_osc_tick : ext_clk_tick;
  assign analog_master_clock_tick = mclk_tick && (pre_cnt_q == pre_last(cfg1_q[`AOCC_CFG1_PRE_MSB:`AOCC_CFG1_PRE_LSB]));

  always_comb begin
    pre_cnt_d = pre_cnt_q;
    analog_master_clock_d = analog_master_clock_q;
    clk_oe_d = (cfg0_q[`AOCC_CFG0_CLK_MSB:`AOCC_CFG0_CLK_LSB] == `AOCC_CLK_INT_OUT);
    if (analog_master_clock_tick) begin
      pre_cnt_d = '0;
      analog_master_clock_d = ~analog_master_clock_q; // analog clock level seen on the pin
    end else if (mclk_tick) begin
      pre_cnt_d = pre_cnt_q + 3'h1;
    end
  end

  // ************************************************
  // conversion sequencer
  // ************************************************
  assign cfg_written = reg_wr_en && (reg_addr == `AOCC_ADDR_CFG0 || reg_addr == `AOCC_ADDR_CFG1);
  assign conv_done = (st_q == AOCC_RUN) && analog_master_clock_tick
    && (osr_cnt_q == osr_value(cfg1_q[`AOCC_CFG1_OSR_MSB:`AOCC_CFG1_OSR_LSB]) - 17'h00001);
  assign oneshot_stop = conv_done && (conversion_mode_select != `AOCC_CONV_CONTINUOUS);

  // a config write restarts the decimation window so no result mixes settings
  always_comb begin
    st_d = st_q;
    osr_cnt_d = osr_cnt_q;
    case (st_q)
      AOCC_IDLE: begin
        osr_cnt_d = '0;
        if (cfg0_q[`AOCC_CFG0_MODE_MSB:`AOCC_CFG0_MODE_LSB] == `AOCC_MODE_CONV) begin
          st_d = AOCC_RUN;
        end
      end
      AOCC_RUN: begin
        if (cfg0_q[`AOCC_CFG0_MODE_MSB:`AOCC_CFG0_MODE_LSB] != `AOCC_MODE_CONV || oneshot_stop) begin
          st_d = AOCC_IDLE;
          osr_cnt_d = '0;
        end else if (cfg_written || conv_done) begin
          osr_cnt_d = '0;
        end else if (analog_master_clock_tick) begin
          osr_cnt_d = osr_cnt_q + 17'h00001;
        end
      end
      default: begin
        st_d = AOCC_IDLE;
        osr_cnt_d = '0;
      end
    endcase
  end

  // ************************************************
  // configuration registers
  // ************************************************
  // software write beats the one-shot return to standby in the same cycle
  always_comb begin
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    if (reg_wr_en && reg_addr == `AOCC_ADDR_CFG0) begin
      cfg0_d = reg_wdata;
    end else if (oneshot_stop) begin
      cfg0_d[`AOCC_CFG0_MODE_MSB:`AOCC_CFG0_MODE_LSB] = `AOCC_MODE_STBY;
    end
    if (reg_wr_en && reg_addr == `AOCC_ADDR_CFG1) begin
      cfg1_d = reg_wdata;
    end
  end

  // ************************************************
  // result path
  // ************************************************
  // offset is added first, then gain scales in 1.23 format
  always_comb begin
    off_sum = $signed({filter_result[23], filter_result});
    if (offset_cal_enable) begin
      off_sum = off_sum + $signed({offset_cal_value[23], offset_cal_value});
    end
    gain_prod = 50'(off_sum);
    if (gain_cal_enable) begin
      gain_prod = 50'($signed(50'(off_sum) * $signed({26'h0, gain_cal_value})) >>> `AOCC_GAIN_FRAC);
    end
    cal_value = sat24(gain_prod);
  end

  // modulator view loads every analog clock tick, filtered view at data ready
  assign buf_load = irq_mode_upper ? analog_master_clock_tick : conv_done;
  assign buf_load_data = irq_mode_upper ? {20'h00000, modulator_raw_output} : cal_value;

  aocc_result_buf #(
    .DW(24)
  ) u_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .load(buf_load),
    .load_data(buf_load_data),
    .load_modulator_raw_output(irq_mode_upper),
    .capture(reg_rd_start && reg_addr == `AOCC_ADDR_RESULT),
    .snap_data(snap_data),
    .snap_modulator_raw_output(snap_modulator_raw_output)
  );

  // ************************************************
  // read answer
  // ************************************************
  // answer one cycle after the snapshot, held until the next read answers
  always_comb begin
    ready_d = buf_load;
    rd_pend_d = reg_rd_start;
    rd_addr_d = reg_rd_start ? reg_addr : rd_addr_q;
    rd_data_d = rd_data_q;
    rd_valid_d = rd_pend_q;
    if (rd_pend_q) begin
      case (rd_addr_q)
        `AOCC_ADDR_RESULT: begin
          if (snap_modulator_raw_output) begin
            rd_data_d = {28'h0000000, snap_data[3:0]};
          end else if (data_format == 2'h0) begin
            rd_data_d = {8'h00, snap_data};
          end else if (data_format == 2'h1) begin
            rd_data_d = {snap_data, 8'h00};
          end else begin
            rd_data_d = {{8{snap_data[23]}}, snap_data};
          end
        end
        `AOCC_ADDR_CFG0: rd_data_d = {24'h000000, cfg0_q};
        `AOCC_ADDR_CFG1: rd_data_d = {24'h000000, cfg1_q};
        default: rd_data_d = 32'h00000000;
      endcase
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg0_q <= `AOCC_CFG0_RESET;
      cfg1_q <= `AOCC_CFG1_RESET;
      pre_cnt_q <= '0;
      osr_cnt_q <= '0;
      st_q <= AOCC_IDLE;
      analog_master_clock_q <= 1'b0;
      clk_oe_q <= 1'b0;
      ready_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 4'h0;
      rd_data_q <= 32'h00000000;
      rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      pre_cnt_q <= pre_cnt_d;
      osr_cnt_q <= osr_cnt_d;
      st_q <= st_d;
      analog_master_clock_q <= analog_master_clock_d;
      clk_oe_q <= clk_oe_d;
      ready_q <= ready_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign vref_internal = cfg0_q[`AOCC_CFG0_VREF_BIT];
  assign partial_shutdown_n = cfg0_q[`AOCC_CFG0_PSHDN_BIT];
  assign bias_current_sel = cfg0_q[`AOCC_CFG0_BIAS_MSB:`AOCC_CFG0_BIAS_LSB];
  assign adc_mode = cfg0_q[`AOCC_CFG0_MODE_MSB:`AOCC_CFG0_MODE_LSB];
  assign oversampling_ratio = cfg1_q[`AOCC_CFG1_OSR_MSB:`AOCC_CFG1_OSR_LSB];
  assign clk_pin_out = analog_master_clock_q;
  assign clk_pin_oe = clk_oe_q;
  assign data_ready = ready_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
endmodule

//--- tb/aocc_core_properties.sv
// checker for the register port, result answers and data ready pulse
`timescale 1ns/10ps
module aocc_core_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr_en,
  input wire aocc_pkg::aocc_byte_t reg_wdata,
  input wire logic reg_rd_start,
  input wire aocc_pkg::aocc_word32_t rd_data,
  input wire logic rd_valid,
  // settings and events
  input wire logic irq_mode_upper,
  input wire logic vref_internal,
  input wire logic [1:0] bias_current_sel,
  input wire logic [1:0] adc_mode,
  input wire logic [3:0] oversampling_ratio,
  input wire logic clk_pin_oe,
  input wire logic data_ready
);
  import aocc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // read answers
  // ****************************************
  property p_rd_answer; clk_en && reg_rd_start |-> ##2 rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_only; rd_valid |-> $past(reg_rd_start, 2); endproperty
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_cfg0_rd;
    reg_rd_start && reg_addr == 4'h1 |-> ##2 rd_data[31:8] == 24'h0 && rd_data[6] == $past(vref_internal, 2)
      && rd_data[3:2] == $past(bias_current_sel, 2) && rd_data[1:0] == $past(adc_mode, 2);
  endproperty
  a_cfg0_rd: assert property (p_cfg0_rd) else $error("config zero readback");
  property p_cfg1_rd;
    reg_rd_start && reg_addr == 4'h2 |-> ##2 rd_data[31:8] == 24'h0 && rd_data[5:2] == $past(oversampling_ratio, 2);
  endproperty
  a_cfg1_rd: assert property (p_cfg1_rd) else $error("ratio readback");
  // ****************************************
  // writes and events
  // ****************************************
  property p_wr_cfg0;
    clk_en && reg_wr_en && reg_addr == 4'h1 |=> adc_mode == $past(reg_wdata[1:0])
      && bias_current_sel == $past(reg_wdata[3:2]) && vref_internal == $past(reg_wdata[6]);
  endproperty
  a_wr_cfg0: assert property (p_wr_cfg0) else $error("config zero write");
  property p_wr_cfg1; clk_en && reg_wr_en && reg_addr == 4'h2 |=> oversampling_ratio == $past(reg_wdata[5:2]); endproperty
  a_wr_cfg1: assert property (p_wr_cfg1) else $error("ratio write");
  property p_oe;
    clk_en && reg_wr_en && reg_addr == 4'h1 && reg_wdata[5:4] == 2'h3 ##1 !reg_wr_en |=> clk_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("clock pin not driven");
  property p_dr_pulse; data_ready && !irq_mode_upper && !$past(irq_mode_upper) |=> !data_ready; endproperty
  a_dr_pulse: assert property (p_dr_pulse) else $error("data ready too long");
  c_dr: cover property (data_ready);
  c_rd_result: cover property (reg_rd_start && reg_addr == 4'h0 ##2 rd_valid);
  c_modulator_raw_output: cover property (irq_mode_upper && rd_valid);
endmodule
bind aocc_core aocc_core_properties aocc_core_properties_i (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_start(reg_rd_start),
  .rd_data(rd_data), .rd_valid(rd_valid), .irq_mode_upper(irq_mode_upper), .vref_internal(vref_internal),
  .bias_current_sel(bias_current_sel), .adc_mode(adc_mode), .oversampling_ratio(oversampling_ratio),
  .clk_pin_oe(clk_pin_oe), .data_ready(data_ready));

//--- tb/aocc_host_model.sv
// host model driving the register port of the converter control
`timescale 1ns/10ps
module aocc_host_model (
  // clock
  input wire logic sys_clk,
  // answers
  input wire aocc_pkg::aocc_word32_t rd_data,
  input wire logic rd_valid,
  input wire logic data_ready,
  // requests
  output logic [3:0] reg_addr,
  output logic reg_wr_en,
  output aocc_pkg::aocc_byte_t reg_wdata,
  output logic reg_rd_start
);
  import aocc_pkg::*;
  // idle port at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_start = 1'b0;
  end
  // write one byte, keeping reserved bits at their required values
  task automatic wr(input logic [3:0] a, input aocc_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr_en <= 1'b1;
    reg_wdata <= (a == 4'h2) ? {d[7:2], 2'h0} : (a == 4'h3) ? (d | 8'h01) : d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d; // released data stops showing the last value
  endtask
  // read one register, bounded wait for the answer
  task automatic rd(input logic [3:0] a, output aocc_word32_t d);
    int n;
    n = 0;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_start <= 1'b1;
    @(posedge sys_clk);
    reg_rd_start <= 1'b0;
    #1;
    while (rd_valid !== 1'b1 && n < 5) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    d = rd_data;
  endtask
  // count cycles up to a data ready pulse, then pass it
  task automatic wait_dr(output int n);
    n = 0;
    #1;
    while (data_ready !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
  endtask
  // read a fresh result, keeping clear of the refresh window
  task automatic rd_result(output aocc_word32_t d);
    int n;
    wait_dr(n);
    wait_dr(n);
    repeat (2) @(posedge sys_clk);
    rd(4'h0, d);
  endtask
endmodule

//--- tb/test_adc_output_and_core_config.sv
// self-checking bench for the output and core config block
`timescale 1ns/10ps
module test_adc_output_and_core_config;
  import aocc_pkg::*;
  logic sys_clk, srst, clk_en, reg_wr_en, reg_rd_start, rd_valid, data_ready, irq_mode_upper;
  logic offset_cal_enable, gain_cal_enable, ext_clk_tick, int_osc_tick;
  logic vref_internal, partial_shutdown_n, clk_pin_out, clk_pin_oe;
  logic [3:0] reg_addr, modulator_raw_output, oversampling_ratio;
  logic [1:0] data_format, conversion_mode_select, bias_current_sel, adc_mode;
  aocc_byte_t reg_wdata;
  aocc_word32_t d;
  aocc_word32_t rd_data;
  aocc_word24_t filter_result, offset_cal_value, gain_cal_value;
  int miscompares, check_count, n;
  aocc_byte_t c1v[6] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h80, 8'hc0};
  int per[6] = '{32, 64, 128, 64, 128, 256};
  aocc_word32_t fmt[4] = '{32'h00876543, 32'h87654300, 32'hff876543, 32'hff876543};
  aocc_core aocc_core_i (.sys_clk, .srst, .clk_en, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_start,
    .rd_data, .rd_valid, .filter_result, .modulator_raw_output, .offset_cal_enable, .gain_cal_enable,
    .offset_cal_value, .gain_cal_value, .data_format, .conversion_mode_select, .irq_mode_upper,
    .ext_clk_tick, .int_osc_tick, .vref_internal, .partial_shutdown_n, .bias_current_sel, .adc_mode,
    .oversampling_ratio, .clk_pin_out, .clk_pin_oe, .data_ready);
  aocc_host_model aocc_host_model_i (.sys_clk, .rd_data, .rd_valid, .data_ready, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_start);
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input aocc_word32_t got, input aocc_word32_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    miscompares = 0;
    check_count = 0;
    {srst, clk_en, int_osc_tick, conversion_mode_select} = 5'h1f;
    {ext_clk_tick, irq_mode_upper, offset_cal_enable, gain_cal_enable} = 4'h0;
    {data_format, modulator_raw_output} = 6'h0;
    {offset_cal_value, gain_cal_value} = 48'h0;
    filter_result = 24'h876543;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    aocc_host_model_i.rd(4'h1, d);
    chk(d, 32'hc0);
    chk(32'(partial_shutdown_n), 32'h1);
    aocc_host_model_i.rd(4'h2, d);
    chk(d, 32'h0c);
    aocc_host_model_i.rd(4'h5, d);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      aocc_host_model_i.wr(4'h1, {4'hc, i[1:0], 2'h0});
      aocc_host_model_i.rd(4'h1, d);
      chk(d, {24'h0, 4'hc, i[1:0], 2'h0});
    end
    // data ready spacing over prescaler and ratio codes, internal clock out
    aocc_host_model_i.wr(4'h1, 8'hf3);
    for (int i = 0; i < 6; i++) begin
      aocc_host_model_i.wr(4'h2, c1v[i]);
      aocc_host_model_i.wait_dr(n);
      aocc_host_model_i.wait_dr(n);
      chk(32'(n + 1), 32'(per[i]));
      chk(32'(clk_pin_oe), 32'h1);
    end
    aocc_host_model_i.wr(4'h2, 8'h00);
    // external clock source idle, then ticking
    aocc_host_model_i.wr(4'h1, 8'hc3);
    aocc_host_model_i.wait_dr(n);
    chk(32'(n), 32'd300);
    @(posedge sys_clk);
    ext_clk_tick <= 1'b1;
    aocc_host_model_i.wait_dr(n);
    aocc_host_model_i.wait_dr(n);
    chk(32'(n + 1), 32'd32);
    // output formats
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      data_format <= k[1:0];
      aocc_host_model_i.rd(4'h0, d);
      chk(d, fmt[k]);
    end
    // new result lands while a read is in flight
    aocc_host_model_i.wait_dr(n);
    @(posedge sys_clk);
    filter_result <= 24'h123456;
    // read start lands on the very edge that loads the new result
    repeat (28) @(posedge sys_clk);
    aocc_host_model_i.rd(4'h0, d);
    chk(d, 32'hff876543);
    aocc_host_model_i.rd_result(d);
    chk(d, 32'h00123456);
    // calibrated result
    @(posedge sys_clk);
    {offset_cal_enable, gain_cal_enable} <= 2'h3;
    {filter_result, offset_cal_value, gain_cal_value} <= {24'h000100, 24'h000100, 24'h400000};
    aocc_host_model_i.rd_result(d);
    chk(d, 32'h00000100);
    // modulator view
    @(posedge sys_clk);
    irq_mode_upper <= 1'b1;
    modulator_raw_output <= 4'ha;
    repeat (4) @(posedge sys_clk);
    aocc_host_model_i.rd(4'h0, d);
    chk(d, 32'h0000000a);
    // one-shot returns to standby
    @(posedge sys_clk);
    irq_mode_upper <= 1'b0;
    conversion_mode_select <= 2'h0;
    aocc_host_model_i.wr(4'h1, 8'hf3);
    aocc_host_model_i.wait_dr(n);
    aocc_host_model_i.wait_dr(n);
    aocc_host_model_i.rd(4'h1, d);
    chk(d, 32'hf2);
    // analog clock pin toggles every master tick at divide by one
    d = 32'(clk_pin_out);
    @(posedge sys_clk);
    #1;
    chk(32'(clk_pin_out), 32'(!d[0]));
    // clock enable low freezes the pin and ignores a write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    aocc_host_model_i.wr(4'h1, 8'h00);
    d = 32'(clk_pin_out);
    repeat (2) @(posedge sys_clk);
    chk(32'(clk_pin_out), d);
    clk_en <= 1'b1;
    aocc_host_model_i.rd(4'h1, d);
    chk(d, 32'hf2);
    tally_and_finish;
  end
endmodule
